// ---- design/motion_event_interrupt_unit.sv ----
// Interrupt and event unit of a motion sensor: APB registers, status, pin and buffer counter.
// Assumes events and samples come from logic on pclk; frame sync arrives from a pin.
//
// Summary of operation
// - Each source has its own enable bit and status flag, except aux nack and lost arbitration, which share one.
// - Software sets pin polarity, open drain, latching and the clearing method.
// - Clock lock onto a new reference raises a source.
// - Fresh sample data raises the data-ready source.
// - A missing acknowledge on the auxiliary bus raises a source.
// - Auxiliary master errors, lost arbitration too, and slave 4 are sources.
// - Buffer counter tracks valid bytes of 1024; exceeding it raises overflow.
// - Only software-selected data categories are written into the buffer.
// - One readable status register shows every pending source.
// - Acceleration passes a configurable high-pass filter before motion checks.
// - A sample qualifies when any filtered axis magnitude exceeds the threshold.
// - Counter rises on qualifying samples and falls on others.
// - Motion interrupt fires when the counter reaches its threshold.
// - Motion flags record the axis and sign that caused the event.
// - Acceleration threshold is one milli-g per step.
// - Counter threshold is one millisecond per count.
// - Non-qualifying samples clear the counter or subtract 1, 2 or 4.
// - Latest measurements sit in read-only registers readable at any time.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "motion_irq_map.svh"
module motion_event_interrupt_unit (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurements
	input wire logic sample_valid,
	input wire logic [15:0] accel_x,
	input wire logic [15:0] accel_y,
	input wire logic [15:0] accel_z,
	input wire logic [15:0] gyro_x,
	input wire logic [15:0] gyro_y,
	input wire logic [15:0] gyro_z,
	input wire logic [15:0] temp_sample,
	// Event sources
	input wire logic clock_lock_done,
	input wire logic aux_nack,
	input wire logic aux_lost_arb,
	input wire logic aux_slave4_done,
	input wire logic buf_pop,
	input wire logic frame_sync_input,
	// Buffer write side
	output logic buf_write,
	output logic [4:0] buf_select,
	output logic buf_frame_sync_input,
	// Interrupt pin
	output logic int_out,
	output logic int_oe
);
	logic [3:0] int_cfg_reg;
	logic [`STAT_W-1:0] int_enable_reg;
	logic [`STAT_W-1:0] status_reg;
	logic [`STAT_W-1:0] status_snap_reg;
	logic [7:0] motion_thr_reg;
	logic [7:0] motion_dur_reg;
	logic [4:0] motion_ctrl_reg;
	logic [9:0] buf_cfg_reg;
	logic [10:0] buf_count_reg;
	logic [15:0] accel_x_reg;
	logic [15:0] accel_y_reg;
	logic [15:0] accel_z_reg;
	logic [15:0] gyro_x_reg;
	logic [15:0] gyro_y_reg;
	logic [15:0] gyro_z_reg;
	logic [15:0] temp_reg;
	logic [10:0] pulse_cnt_reg;
	logic frame_sync_input_meta_reg;
	logic frame_sync_input_sync_reg;
	logic [31:0] rd_data;
	logic rd_hit;
	logic access;
	logic wr_en;
	logic rd_done;
	logic [`STAT_W-1:0] events;
	logic [`STAT_W-1:0] clear_mask;
	logic pulse_expire;
	logic motion_event;
	logic [5:0] motion_flags;
	logic [4:0] aux_bytes;
	logic [5:0] bytes_add;
	logic [11:0] count_sum;
	logic overflow;
	logic irq_level;
	logic pin_level;

	// ==========================================================
	// Frame sync pin synchroniser
	// Only the second stage feeds logic; the first may be metastable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync_input_meta_reg <= 1'b0;
			frame_sync_input_sync_reg <= 1'b0;
		end else if (ce) begin
			frame_sync_input_meta_reg <= frame_sync_input;
			frame_sync_input_sync_reg <= frame_sync_input_meta_reg;
		end
	end

	// ==========================================================
	// APB handshake: one wait-free access phase after every setup
	// Qualifying by pready keeps a held access from writing twice
	assign access = psel & penable & pready;
	assign wr_en = access & pwrite;
	assign rd_done = access & ~pwrite;

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			`OFS_INT_CFG: rd_data = {28'h000_0000, int_cfg_reg};
			`OFS_INT_ENABLE: rd_data = {26'h0, int_enable_reg};
			`OFS_INT_STATUS: rd_data = {26'h0, status_reg};
			`OFS_MOTION_THR: rd_data = {24'h00_0000, motion_thr_reg};
			`OFS_MOTION_DUR: rd_data = {24'h00_0000, motion_dur_reg};
			`OFS_MOTION_CTRL: rd_data = {27'h0, motion_ctrl_reg};
			`OFS_MOTION_FLAGS: rd_data = {26'h0, motion_flags};
			`OFS_BUF_CFG: rd_data = {19'h0, buf_cfg_reg[9:5], 3'h0, buf_cfg_reg[4:0]};
			`OFS_BUF_COUNT: rd_data = {21'h0, buf_count_reg};
			`OFS_ACCEL_XY: rd_data = {accel_y_reg, accel_x_reg};
			`OFS_ACCEL_Z_TEMP: rd_data = {temp_reg, accel_z_reg};
			`OFS_GYRO_XY: rd_data = {gyro_y_reg, gyro_x_reg};
			`OFS_GYRO_Z: rd_data = {16'h0000, gyro_z_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	// Snapshot at setup so a read clears only flags already set when it began
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			status_snap_reg <= {`STAT_W{1'b0}};
		end else if (ce) begin
			pready <= psel & ~penable & ~pready;
			if (psel && !penable && !pready) begin
				pslverr <= ~rd_hit;
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
				status_snap_reg <= status_reg;
			end
		end
	end

	// ==========================================================
	// Writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_cfg_reg <= `RST_INT_CFG;
			int_enable_reg <= `RST_INT_ENABLE;
			motion_thr_reg <= `RST_MOTION_THR;
			motion_dur_reg <= `RST_MOTION_DUR;
			motion_ctrl_reg <= `RST_MOTION_CTRL;
			buf_cfg_reg <= `RST_BUF_CFG;
		end else if (ce && wr_en) begin
			case (paddr)
				`OFS_INT_CFG: int_cfg_reg <= pwdata[3:0];
				`OFS_INT_ENABLE: int_enable_reg <= pwdata[`STAT_W-1:0];
				`OFS_MOTION_THR: motion_thr_reg <= pwdata[7:0];
				`OFS_MOTION_DUR: motion_dur_reg <= pwdata[7:0];
				`OFS_MOTION_CTRL: motion_ctrl_reg <= pwdata[4:0];
				`OFS_BUF_CFG: buf_cfg_reg <= {pwdata[12:8], pwdata[4:0]};
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Sensor data registers
	// Captured on the sample strobe so a read never mixes two samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accel_x_reg <= 16'h0000;
			accel_y_reg <= 16'h0000;
			accel_z_reg <= 16'h0000;
			gyro_x_reg <= 16'h0000;
			gyro_y_reg <= 16'h0000;
			gyro_z_reg <= 16'h0000;
			temp_reg <= 16'h0000;
		end else if (ce && sample_valid) begin
			accel_x_reg <= accel_x;
			accel_y_reg <= accel_y;
			accel_z_reg <= accel_z;
			gyro_x_reg <= gyro_x;
			gyro_y_reg <= gyro_y;
			gyro_z_reg <= gyro_z;
			temp_reg <= temp_sample;
		end
	end

	// ==========================================================
	// Motion detector
	motion_detector u_motion (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.sample_valid(sample_valid),
		.accel_xyz({accel_z, accel_y, accel_x}),
		.motion_accel_threshold(motion_thr_reg),
		.motion_count_threshold(motion_dur_reg),
		.motion_decrement_control(motion_irq_pkg::decrement_mode_t'(motion_ctrl_reg[1:0])),
		.accel_highpass_filter(motion_ctrl_reg[4:2]),
		.motion_event(motion_event),
		.motion_source_flags(motion_flags)
	);

	// ==========================================================
	// Buffer byte counter
	// Aux byte count above the slave limit is clipped rather than trusted
	assign aux_bytes = (buf_cfg_reg[9:5] > `AUX_MAX_BYTES) ? `AUX_MAX_BYTES : buf_cfg_reg[9:5];

	always_comb begin
		bytes_add = 6'h00;
		if (sample_valid) begin
			if (buf_cfg_reg[0]) bytes_add = bytes_add + `BYTES_GYRO;
			if (buf_cfg_reg[1]) bytes_add = bytes_add + `BYTES_ACCEL;
			if (buf_cfg_reg[2]) bytes_add = bytes_add + `BYTES_TEMP;
			if (buf_cfg_reg[3]) bytes_add = bytes_add + {1'b0, aux_bytes};
			if (buf_cfg_reg[4]) bytes_add = bytes_add + `BYTES_FRAME_SYNC_INPUT;
		end
		count_sum = {1'b0, buf_count_reg} + {6'h00, bytes_add};
		if (buf_pop && buf_count_reg != 11'h000) begin
			count_sum = count_sum - 12'h001;
		end
	end

	// Overwrite-oldest trade-off: count pins at capacity, host sees overflow
	assign overflow = count_sum > `BUF_CAPACITY;

	// A pop at an empty buffer is dropped rather than wrapping the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_count_reg <= 11'h000;
		end else if (ce) begin
			buf_count_reg <= overflow ? 11'(`BUF_CAPACITY) : count_sum[10:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_write <= 1'b0;
			buf_select <= 5'h00;
			buf_frame_sync_input <= 1'b0;
		end else if (ce) begin
			buf_write <= sample_valid & (|buf_cfg_reg[4:0]);
			if (sample_valid) begin
				buf_select <= buf_cfg_reg[4:0];
				buf_frame_sync_input <= frame_sync_input_sync_reg;
			end
		end
	end

	// ==========================================================
	// Interrupt status
	always_comb begin
		events = {`STAT_W{1'b0}};
		events[`STAT_DATA_READY] = sample_valid;
		events[`STAT_CLOCK_LOCK] = clock_lock_done;
		events[`STAT_AUX_ERROR] = aux_nack | aux_lost_arb;
		events[`STAT_AUX_SLAVE4] = aux_slave4_done;
		events[`STAT_BUF_OVERFLOW] = overflow;
		events[`STAT_MOTION] = motion_event;
	end

	always_comb begin
		clear_mask = {`STAT_W{1'b0}};
		if (rd_done && (int_cfg_reg[`CFG_ANY_READ_CLEAR] || paddr == `OFS_INT_STATUS)) begin
			clear_mask = status_snap_reg;
		end
		if (pulse_expire && !int_cfg_reg[`CFG_LATCH]) begin
			clear_mask = {`STAT_W{1'b1}};
		end
	end

	// Unlatched flags last one pulse width after the latest event
	assign pulse_expire = (pulse_cnt_reg == 11'h001) & ~(|events);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_cnt_reg <= 11'h000;
		end else if (ce) begin
			if (|events) begin
				pulse_cnt_reg <= 11'(`INT_PULSE_CYCLES);
			end else if (pulse_cnt_reg != 11'h000) begin
				pulse_cnt_reg <= pulse_cnt_reg - 11'h001;
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < `STAT_W; i = i + 1) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status_reg[i] <= 1'b0;
				end else if (ce) begin
					// Set wins over a clear in the same cycle
					if (events[i]) begin
						status_reg[i] <= 1'b1;
					end else if (clear_mask[i]) begin
						status_reg[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Interrupt pin
	assign irq_level = |(status_reg & int_enable_reg);
	assign pin_level = irq_level ^ int_cfg_reg[`CFG_ACTIVE_LOW];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_out <= 1'b0;
		end else if (ce) begin
			int_out <= pin_level;
		end
	end

	// Open drain only pulls low; the high level comes from the pull-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_oe <= 1'b1;
		end else if (ce) begin
			int_oe <= ~int_cfg_reg[`CFG_OPEN_DRAIN] | ~pin_level;
		end
	end
endmodule // motion_event_interrupt_unit

// ---- pkg/motion_irq_map.svh ----
// Register map, field positions, reset values and timing counts of the interrupt unit.
// Assumes byte addressing on an APB bus with 32-bit data, one aligned word per register.
`ifndef MOTION_IRQ_MAP_SVH
`define MOTION_IRQ_MAP_SVH

// ==========================================================
// Register offsets
`define OFS_INT_CFG 8'h00
`define OFS_INT_ENABLE 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_MOTION_THR 8'h0c
`define OFS_MOTION_DUR 8'h10
`define OFS_MOTION_CTRL 8'h14
`define OFS_MOTION_FLAGS 8'h18
`define OFS_BUF_CFG 8'h1c
`define OFS_BUF_COUNT 8'h20
`define OFS_ACCEL_XY 8'h24
`define OFS_ACCEL_Z_TEMP 8'h28
`define OFS_GYRO_XY 8'h2c
`define OFS_GYRO_Z 8'h30

// ==========================================================
// Field positions
`define CFG_ACTIVE_LOW 0
`define CFG_OPEN_DRAIN 1
`define CFG_LATCH 2
`define CFG_ANY_READ_CLEAR 3
`define STAT_DATA_READY 0
`define STAT_CLOCK_LOCK 1
`define STAT_AUX_ERROR 2
`define STAT_AUX_SLAVE4 3
`define STAT_BUF_OVERFLOW 4
`define STAT_MOTION 5
`define STAT_W 6
`define SEL_W 5

// ==========================================================
// Reset values
`define RST_INT_CFG 4'h0
`define RST_INT_ENABLE 6'h00
`define RST_MOTION_THR 8'h00
`define RST_MOTION_DUR 8'h00
`define RST_MOTION_CTRL 5'h00
`define RST_BUF_CFG 10'h000

// ==========================================================
// Buffer sizes and timing
`define BUF_CAPACITY 12'h400
`define BYTES_GYRO 6'h06
`define BYTES_ACCEL 6'h06
`define BYTES_TEMP 6'h02
`define BYTES_FRAME_SYNC_INPUT 6'h02
`define AUX_MAX_BYTES 5'h18
`define PCLK_MHZ 40
`define INT_PULSE_NS 50000
`define INT_PULSE_CYCLES ((`INT_PULSE_NS * `PCLK_MHZ) / 1000)

`endif

// ---- pkg/motion_irq_pkg.sv ----
// Types shared by the interrupt unit and its motion detector.
// Assumes nothing beyond a SystemVerilog compiler.
package motion_irq_pkg;

	// ==========================================================
	// Motion counter behaviour on a non-qualifying sample
	typedef enum logic [1:0] {
		DEC_RESET,
		DEC_ONE,
		DEC_TWO,
		DEC_FOUR
	} decrement_mode_t;

endpackage

// ---- design/motion_detector.sv ----
// Motion detector: high-pass filter, threshold qualifier and up/down duration counter.
// Assumes accel samples in milli-g, one sample per millisecond, on the pclk domain.
`timescale 1ns/1ps
module motion_detector (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Samples
	input wire logic sample_valid,
	input wire logic [47:0] accel_xyz,
	// Settings
	input wire logic [7:0] motion_accel_threshold,
	input wire logic [7:0] motion_count_threshold,
	input wire motion_irq_pkg::decrement_mode_t motion_decrement_control,
	input wire logic [2:0] accel_highpass_filter,
	// Results
	output logic motion_event,
	output logic [5:0] motion_source_flags
);
	logic [2:0] qual_pos;
	logic [2:0] qual_neg;
	logic qualify;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [7:0] step;
	logic [7:0] dur_eff;

	// ==========================================================
	// Per-axis filter and qualifier
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_axis
			logic signed [15:0] x;
			logic signed [15:0] avg_reg;
			logic signed [16:0] diff;
			logic signed [16:0] hp;
			logic signed [16:0] avg_step;
			logic [16:0] mag;
			assign x = accel_xyz[16*g +: 16];
			assign diff = {x[15], x} - {avg_reg[15], avg_reg};
			// Filter off passes raw samples, gravity included
			assign hp = (accel_highpass_filter == 3'h0) ? {x[15], x} : diff;
			// Signed sum keeps the shift arithmetic when the input falls
			assign avg_step = $signed({avg_reg[15], avg_reg}) + (diff >>> accel_highpass_filter);
			assign mag = hp[16] ? 17'(-hp) : 17'(hp);
			assign qual_pos[g] = ~hp[16] & (mag > {9'h000, motion_accel_threshold});
			assign qual_neg[g] = hp[16] & (mag > {9'h000, motion_accel_threshold});
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					avg_reg <= 16'sh0000;
				end else if (ce && sample_valid) begin
					avg_reg <= avg_step[15:0];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Duration counter
	assign qualify = |(qual_pos | qual_neg);
	// A zero threshold would never be crossed, so it acts as one
	assign dur_eff = (motion_count_threshold == 8'h00) ? 8'h01 : motion_count_threshold;

	always_comb begin
		step = 8'h01;
		case (motion_decrement_control)
			motion_irq_pkg::DEC_TWO: step = 8'h02;
			motion_irq_pkg::DEC_FOUR: step = 8'h04;
			default: step = 8'h01;
		endcase
		if (qualify) begin
			count_next = (count_reg == 8'hff) ? 8'hff : count_reg + 8'h01;
		end else if (motion_decrement_control == motion_irq_pkg::DEC_RESET) begin
			count_next = 8'h00;
		end else begin
			count_next = (count_reg > step) ? count_reg - step : 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 8'h00;
			motion_event <= 1'b0;
			motion_source_flags <= 6'h00;
		end else if (ce) begin
			motion_event <= 1'b0;
			if (sample_valid) begin
				count_reg <= count_next;
				// Counts are samples, so at 1 kHz one count is 1 ms
				if (qualify && (count_reg < dur_eff) && (count_next >= dur_eff)) begin
					motion_event <= 1'b1;
					motion_source_flags <= {qual_neg[2], qual_pos[2], qual_neg[1], qual_pos[1],
						qual_neg[0], qual_pos[0]};
				end
			end
		end
	end
endmodule // motion_detector

// ---- testbench/mei_checker_properties.sv ----
// Checker for the interrupt unit: APB answer timing, read data shape, buffer strobes.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module mei_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Buffer side
	input wire logic sample_valid,
	input wire logic buf_write,
	input wire logic [4:0] buf_select
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Properties
	property p_answer;
		psel && !penable && !pready && ce |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");
	property p_one_cycle;
		pready && ce |=> !pready;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("pready too long");
	property p_err;
		pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h30);
	endproperty
	a_err: assert property (p_err) else $error("wrong error response");
	property p_quiet;
		pready && (pwrite || pslverr) |-> prdata == 32'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("read data not zero");
	property p_status;
		pready && !pwrite && paddr == 8'h08 |-> prdata[31:6] == 26'h0;
	endproperty
	a_status: assert property (p_status) else $error("status upper bits set");
	property p_count;
		pready && !pwrite && paddr == 8'h20 |-> prdata <= 32'h400;
	endproperty
	a_count: assert property (p_count) else $error("count above capacity");
	property p_flags;
		pready && !pwrite && paddr == 8'h18 |-> prdata[31:6] == 26'h0;
	endproperty
	a_flags: assert property (p_flags) else $error("flags upper bits set");
	property p_strobe;
		buf_write |-> $past(sample_valid) && buf_select != 5'h00;
	endproperty
	a_strobe: assert property (p_strobe) else $error("stray buffer write");
	property p_ro;
		pready && !pwrite && paddr == 8'h30 |-> prdata[31:16] == 16'h0;
	endproperty
	a_ro: assert property (p_ro) else $error("sample word upper bits set");
endmodule // mei_checker

bind motion_event_interrupt_unit mei_checker u_mei_checker (.pclk, .presetn, .ce, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sample_valid, .buf_write,
	.buf_select);

// ---- testbench/host_pin_model.sv ----
// Host end of the interrupt pin: pull-up resistor and input buffer.
// Assumes the unit drives the pin only while its output enable is high.
`timescale 1ns/1ps
module host_pin_model (
	// Pin drivers
	input wire logic int_out,
	input wire logic int_oe,
	// Level seen by the host
	output logic pin
);
	// ==========================================================
	// Pin level
	// Released pin rises through the pull-up, as open drain needs
	assign pin = int_oe ? int_out : 1'b1;
endmodule // host_pin_model

// ---- testbench/motion_event_interrupt_unit_tb.sv ----
// Self-checking bench: APB master, event sources, motion samples, buffer count.
// Assumes package, map header, pin model and checker are compiled first.
`timescale 1ns/1ps
module motion_event_interrupt_unit_tb;
	localparam int sb[5] = '{1, 2, 2, 3, 0};
	localparam int need[4] = '{6, 3, 5, 6};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sample_valid = 1'b0;
	logic buf_pop = 1'b0;
	logic ce = 1'b1;
	logic sync_in = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] ax = 16'h0, ay = 16'h0, az = 16'h0, gx = 16'h0, gy = 16'h0;
	logic [15:0] gz = 16'h0, tp = 16'h0;
	logic [3:0] ev = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, buf_write, buf_frame_sync_input, int_out, int_oe, pin;
	logic [4:0] buf_select;
	logic [32:0] exp_q[$];
	logic [15:0] r[7];
	int n_errors = 0;
	int checks_done = 0;
	int n_bw = 0;
	int seed = 32'h28b8;

	motion_event_interrupt_unit u_motion_event_interrupt_unit (.pclk(pclk),
		.presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .accel_x(ax), .accel_y(ay),
		.accel_z(az), .gyro_x(gx), .gyro_y(gy), .gyro_z(gz), .temp_sample(tp),
		.clock_lock_done(ev[0]), .aux_nack(ev[1]), .aux_lost_arb(ev[2]),
		.aux_slave4_done(ev[3]), .buf_pop(buf_pop), .frame_sync_input(sync_in),
		.buf_write(buf_write), .buf_select(buf_select), .buf_frame_sync_input(buf_frame_sync_input),
		.int_out(int_out), .int_oe(int_oe));
	host_pin_model u_host_pin_model (.int_out(int_out), .int_oe(int_oe), .pin(pin));

	// ==========================================================
	// Clock, monitor, watchdog
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (buf_write === 1'b1)
			n_bw++;
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, exp_q.pop_front());
	end
	initial begin
		cyc(40000);
		n_errors++;
		conclude();
	end

	// ==========================================================
	// Tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic check(input logic [32:0] got, input logic [32:0] want);
		checks_done++;
		if (got !== want) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// Idle edge after release keeps psel from two writes in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		ax <= x;
		ay <= y;
		az <= z;
		sample_valid <= 1'b1;
		cyc(1);
		sample_valid <= 1'b0;
		cyc(5);
	endtask
	task automatic smp3(input int axis, input logic [15:0] v);
		smp(axis == 0 ? v : 16'h0, axis == 1 ? v : 16'h0, axis == 2 ? v : 16'h0);
	endtask
	task automatic fire(input int k);
		if (k == 4) begin
			smp3(0, 16'h0);
		end else begin
			ev[k] <= 1'b1;
			cyc(1);
			ev[k] <= 1'b0;
			cyc(5);
		end
	endtask
	task automatic conclude();
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] v;
		cyc(3);
		presetn <= 1'b1;
		cyc(1);
		for (int a = 0; a <= 'h30; a += 4)
			rd(a[7:0], 33'h0);
		rd(8'h34, 33'h100000000);
		rd(8'h02, 33'h100000000);
		wr(8'h00, 32'h4);
		for (int k = 0; k < 5; k++) begin
			wr(8'h04, 32'h3f ^ (32'h1 << sb[k]));
			fire(k);
			check({32'h0, int_out}, 33'h0);
			rd(8'h08, 33'h1 << sb[k]);
			wr(8'h04, 32'h1 << sb[k]);
			fire(k);
			cyc(2100);
			check({32'h0, int_out}, 33'h1);
			rd(8'h08, 33'h1 << sb[k]);
			cyc(2);
			check({32'h0, int_out}, 33'h0);
		end
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h3f);
		fire(0);
		cyc(1980);
		check({32'h0, int_out}, 33'h1);
		cyc(40);
		check({32'h0, int_out}, 33'h0);
		rd(8'h08, 33'h0);
		// Clock enable low: an event pulse is not taken
		ce <= 1'b0;
		fire(0);
		check({32'h0, int_out}, 33'h0);
		ce <= 1'b1;
		rd(8'h08, 33'h0);
		wr(8'h00, 32'h7);
		fire(1);
		check({31'h0, int_oe, pin}, 33'h2);
		rd(8'h08, 33'h4);
		cyc(2);
		check({31'h0, int_oe, pin}, 33'h1);
		wr(8'h00, 32'hc);
		fire(3);
		rd(8'h00, 33'hc);
		rd(8'h08, 33'h0);
		wr(8'h00, 32'h4);
		wr(8'h0c, 32'h64);
		wr(8'h10, 32'h6);
		for (int m = 0; m < 4; m++) begin
			v = m[0] ? 16'hff9b : 16'h0065;
			wr(8'h14, 32'h0);
			smp3(0, 16'h0);
			wr(8'h14, m);
			rd(8'h08, 33'h1);
			repeat (5) smp3(m % 3, v);
			repeat (2) smp3(m % 3, m[0] ? 16'hff9c : 16'h0064);
			repeat (need[m] - 1) smp3(m % 3, v);
			rd(8'h08, 33'h1);
			smp3(m % 3, v);
			rd(8'h08, 33'h21);
			rd(8'h18, 33'h1 << (2 * (m % 3) + m[0]));
		end
		// Filter settles on a flat input, then a step gives one qualifying sample
		wr(8'h14, 32'h4);
		wr(8'h10, 32'h2);
		wr(8'h0c, 32'h78);
		repeat (20) smp3(0, 16'h0);
		rd(8'h08, 33'h1);
		repeat (3) smp3(0, 16'h00c8);
		rd(8'h08, 33'h1);
		wr(8'h14, 32'h0);
		wr(8'h1c, 32'h3);
		check(33'(n_bw), 33'h0);
		repeat (85) smp3(0, 16'h0);
		rd(8'h20, 33'h3fc);
		rd(8'h08, 33'h1);
		smp3(0, 16'h0);
		rd(8'h20, 33'h400);
		rd(8'h08, 33'h11);
		buf_pop <= 1'b1;
		cyc(4);
		buf_pop <= 1'b0;
		cyc(1);
		rd(8'h20, 33'h3fc);
		wr(8'h1c, 32'h16);
		sync_in <= 1'b1;
		cyc(3);
		smp3(0, 16'h0);
		check({27'h0, buf_frame_sync_input, buf_select}, 33'h36);
		check(33'(n_bw), 33'h57);
		for (int i = 0; i < 7; i++)
			r[i] = 16'($random(seed));
		gx <= r[3];
		gy <= r[4];
		gz <= r[5];
		tp <= r[6];
		smp(r[0], r[1], r[2]);
		rd(8'h24, {1'b0, r[1], r[0]});
		rd(8'h28, {1'b0, r[6], r[2]});
		rd(8'h2c, {1'b0, r[4], r[3]});
		wr(8'h30, 32'hffffffff);
		rd(8'h30, {17'h0, r[5]});
		conclude();
	end
endmodule // motion_event_interrupt_unit_tb
